/* core/pacr_mgmt_top.sv */
`timescale 1ns/1ps
module pacr_mgmt_top
    import pacr_pkg::*;
(
    // clock, reset, enable
    input wire logic clk,
    input wire logic reset_n,
    input wire logic clk_en,
    // management pins
    input wire logic mdc,
    input wire logic mdio_i,
    output logic mdio_o,
    output logic mdio_oe_n,
    // chip address straps, caught after reset release
    input wire logic [2:0] chip_addr_strap,
    // per-port negotiation and link state
    input wire pacr_stat_t [PORTS-1:0] port_stat,
    output pacr_ctl_t [PORTS-1:0] port_ctl,
    // per-port switch side data
    input wire logic [PORTS-1:0] port_transmit_data,
    input wire logic [PORTS-1:0] port_transmit_enable,
    output logic [PORTS-1:0] port_receive_data,
    output logic [PORTS-1:0] port_collision,
    // per-port network side data
    input wire logic [PORTS-1:0] net_receive_data,
    input wire logic [PORTS-1:0] net_collision,
    output logic [PORTS-1:0] net_transmit_data,
    output logic [PORTS-1:0] net_transmit_enable
);

    // ----------------------------------------
    // reset release
    // ----------------------------------------
    logic rst_s1_ff;
    logic rst_s2_ff;
    logic rst_n;

    // left ungated so a stopped enable cannot hold the design in reset
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rst_s1_ff <= 1'b0;
            rst_s2_ff <= 1'b0;
        end else begin
            rst_s1_ff <= 1'b1;
            rst_s2_ff <= rst_s1_ff;
        end
    end
    assign rst_n = rst_s2_ff;

    // ----------------------------------------
    // pin synchronisers
    // ----------------------------------------
    logic mdc_s1_ff;
    logic mdc_s2_ff;
    logic mdc_d_ff;
    logic mdio_s1_ff;
    logic mdio_s2_ff;
    logic [2:0] strap_s1_ff;
    logic [2:0] strap_s2_ff;
    logic mdc_rise;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            mdc_s1_ff <= 1'b0;
            mdc_s2_ff <= 1'b0;
            mdc_d_ff <= 1'b0;
            mdio_s1_ff <= 1'b1;
            mdio_s2_ff <= 1'b1;
            strap_s1_ff <= '0;
            strap_s2_ff <= '0;
        end else if (clk_en) begin
            mdc_s1_ff <= mdc;
            mdc_s2_ff <= mdc_s1_ff;
            mdc_d_ff <= mdc_s2_ff;
            mdio_s1_ff <= mdio_i;
            mdio_s2_ff <= mdio_s1_ff;
            strap_s1_ff <= chip_addr_strap;
            strap_s2_ff <= strap_s1_ff;
        end
    end
    // edge seen on the second stage only
    assign mdc_rise = mdc_s2_ff & ~mdc_d_ff;

    // ----------------------------------------
    // chip address capture
    // ----------------------------------------
    logic [1:0] strap_cnt_ff;
    logic [2:0] chip_ff;

    // wait until the synchroniser holds real strap levels, then freeze
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            strap_cnt_ff <= '0;
            chip_ff <= '0;
        end else if (clk_en) begin
            if (strap_cnt_ff != STRAP_SETTLE + 2'h1) begin // stop one past, capture fires once
                strap_cnt_ff <= strap_cnt_ff + 2'h1;
            end
            if (strap_cnt_ff == STRAP_SETTLE) begin // second stage valid only now
                chip_ff <= strap_s2_ff;
            end
        end
    end

    // ----------------------------------------
    // per-port registers
    // ----------------------------------------
    logic [PORTS-1:0] wr_pls_ff;
    logic [PORTS-1:0] rdc_pls_ff;
    logic [15:0] wdat_ff;
    logic [PORTS-1:0][15:0] ctl_q;
    logic [PORTS-1:0][15:0] sts_q;

    // separate register pair for every port
    for (genvar p = 0; p < PORTS; p++) begin : g_regs
        pacr_port_regs u_regs (
            .clk(clk),
            .rst_n(rst_n),
            .clk_en(clk_en),
            .wr_ctl(wr_pls_ff[p]),
            .wr_data(wdat_ff),
            .rd_sts(rdc_pls_ff[p]),
            .stat(port_stat[p]),
            .ctl_o(port_ctl[p]),
            .ctl_q(ctl_q[p]),
            .sts_q(sts_q[p])
        );
    end

    // ----------------------------------------
    // frame decode helpers
    // ----------------------------------------
    function automatic logic reg_hit(input logic [4:0] ra);
        reg_hit = (ra == REG_CTL) || (ra == REG_STS);
    endfunction

    function automatic logic [PORTS-1:0] port_sel(input logic [1:0] pa);
        port_sel = '0;
        port_sel[pa] = 1'b1;
    endfunction

    // ----------------------------------------
    // management frame engine
    // ----------------------------------------
    pacr_mstate_t ms_ff;
    logic [15:0] sh_ff;
    logic [15:0] out_ff;
    logic [3:0] cnt_ff;
    logic prv_ff;
    logic rd_ff;
    logic wr_ff;
    logic [1:0] port_ff;
    logic [4:0] reg_ff;
    logic drv_ff;
    logic mdo_ff;
    logic [11:0] hdr;
    logic [1:0] h_op;
    logic [1:0] h_port;
    logic [4:0] h_reg;
    logic h_hit;
    logic [15:0] rd_word;

    // the completed header is the twelve bits after the start pair
    always_comb begin
        hdr = {sh_ff[10:0], mdio_s2_ff};
        h_op = hdr[HDR_OP_HI:HDR_OP_LO];
        h_port = hdr[HDR_PORT_HI:HDR_PORT_LO];
        h_reg = hdr[HDR_REG_HI:0];
        h_hit = (hdr[HDR_CHIP_HI:HDR_CHIP_LO] == chip_ff) && reg_hit(h_reg);
        rd_word = (h_reg == REG_STS) ? sts_q[h_port] : ctl_q[h_port];
    end

    // start is a zero then a one, so preamble is optional
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ms_ff <= MS_IDLE;
            cnt_ff <= '0;
            prv_ff <= 1'b1;
            sh_ff <= '0;
        end else if (clk_en && mdc_rise) begin
            sh_ff <= {sh_ff[14:0], mdio_s2_ff};
            unique case (ms_ff)
                MS_IDLE: begin
                    prv_ff <= mdio_s2_ff;
                    cnt_ff <= '0;
                    if (!prv_ff && mdio_s2_ff) begin
                        ms_ff <= MS_HDR;
                    end
                end
                MS_HDR: begin
                    cnt_ff <= cnt_ff + 4'h1;
                    if (cnt_ff == HDR_LAST) begin
                        cnt_ff <= '0;
                        ms_ff <= MS_TA;
                    end
                end
                MS_TA: begin
                    cnt_ff <= cnt_ff + 4'h1;
                    if (cnt_ff == TA_LAST) begin
                        cnt_ff <= '0;
                        ms_ff <= MS_DATA;
                    end
                end
                MS_DATA: begin
                    cnt_ff <= cnt_ff + 4'h1;
                    if (cnt_ff == DATA_LAST) begin
                        cnt_ff <= '0;
                        prv_ff <= 1'b1;
                        ms_ff <= MS_IDLE;
                    end
                end
                default: begin
                    ms_ff <= MS_IDLE;
                    prv_ff <= 1'b1;
                end
            endcase
        end
    end

    // access kind and target, latched at the end of the header
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rd_ff <= 1'b0;
            wr_ff <= 1'b0;
            port_ff <= '0;
            reg_ff <= '0;
        end else if (clk_en && mdc_rise && ms_ff == MS_HDR && cnt_ff == HDR_LAST) begin
            rd_ff <= h_hit && (h_op == OP_RD);
            wr_ff <= h_hit && (h_op == OP_WR);
            port_ff <= h_port;
            reg_ff <= h_reg;
        end
    end

    // read data is snapshotted at header end so it cannot tear mid-frame
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            out_ff <= '0;
            drv_ff <= 1'b0;
            mdo_ff <= 1'b1;
        end else if (clk_en && mdc_rise) begin
            if (ms_ff == MS_HDR && cnt_ff == HDR_LAST) begin
                out_ff <= rd_word;
            end else if (ms_ff == MS_TA && rd_ff) begin
                drv_ff <= 1'b1;
                if (cnt_ff == TA_LAST) begin
                    mdo_ff <= out_ff[15];
                    out_ff <= {out_ff[14:0], 1'b0};
                end else begin
                    mdo_ff <= 1'b0;
                end
            end else if (ms_ff == MS_DATA && rd_ff && cnt_ff != DATA_LAST) begin
                mdo_ff <= out_ff[15];
                out_ff <= {out_ff[14:0], 1'b0};
            end else begin
                drv_ff <= 1'b0;
                mdo_ff <= 1'b1;
            end
        end
    end
    assign mdio_o = mdo_ff;
    assign mdio_oe_n = ~drv_ff;

    // ----------------------------------------
    // register access pulses
    // ----------------------------------------
    // one enabled cycle wide; status writes are dropped
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_pls_ff <= '0;
            rdc_pls_ff <= '0;
            wdat_ff <= '0;
        end else if (clk_en) begin
            wr_pls_ff <= '0;
            rdc_pls_ff <= '0;
            if (mdc_rise && ms_ff == MS_HDR && cnt_ff == HDR_LAST && h_hit
                && h_op == OP_RD && h_reg == REG_STS) begin
                rdc_pls_ff <= port_sel(h_port);
            end
            if (mdc_rise && ms_ff == MS_DATA && cnt_ff == DATA_LAST && wr_ff
                && reg_ff == REG_CTL) begin
                wr_pls_ff <= port_sel(port_ff);
                wdat_ff <= {sh_ff[14:0], mdio_s2_ff};
            end
        end
    end

    // ----------------------------------------
    // per-port data path
    // ----------------------------------------
    logic [PORTS-1:0] rxd_ff;
    logic [PORTS-1:0] col_ff;
    logic [PORTS-1:0] txd_ff;
    logic [PORTS-1:0] txe_ff;

    // loopback keeps the wire quiet, so link partners see an idle port
    for (genvar p = 0; p < PORTS; p++) begin : g_path
        always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
                rxd_ff[p] <= 1'b0;
                col_ff[p] <= 1'b0;
                txd_ff[p] <= 1'b0;
                txe_ff[p] <= 1'b0;
            end else if (clk_en) begin
                if (port_ctl[p].loopback) begin
                    rxd_ff[p] <= port_transmit_data[p];
                    txd_ff[p] <= 1'b0;
                    txe_ff[p] <= 1'b0;
                end else begin
                    rxd_ff[p] <= net_receive_data[p];
                    txd_ff[p] <= port_transmit_data[p];
                    txe_ff[p] <= port_transmit_enable[p];
                end
                col_ff[p] <= (port_ctl[p].collision_test & port_transmit_enable[p])
                    | (net_collision[p] & ~port_ctl[p].loopback);
            end
        end
    end
    assign port_receive_data = rxd_ff;
    assign port_collision = col_ff;
    assign net_transmit_data = txd_ff;
    assign net_transmit_enable = txe_ff;

endmodule

/* core/pacr_pkg.sv */
package pacr_pkg;

    // ----------------------------------------
    // geometry and timing
    // ----------------------------------------
    localparam int PORTS = 4;
    localparam int CLK_PERIOD_PS = 4000;
    localparam int SRST_TIME_US = 10;
    // least time, so round up to whole cycles
    localparam int SRST_CYC = (SRST_TIME_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam logic [11:0] SRST_LOAD = 12'(SRST_CYC);
    localparam logic [1:0] STRAP_SETTLE = 2'h2;

    // ----------------------------------------
    // management frame layout
    // ----------------------------------------
    localparam logic [1:0] OP_RD = 2'h2;
    localparam logic [1:0] OP_WR = 2'h1;
    localparam logic [3:0] HDR_LAST = 4'hb;
    localparam logic [3:0] TA_LAST = 4'h1;
    localparam logic [3:0] DATA_LAST = 4'hf;
    localparam int HDR_OP_HI = 11;
    localparam int HDR_OP_LO = 10;
    localparam int HDR_CHIP_HI = 9;
    localparam int HDR_CHIP_LO = 7;
    localparam int HDR_PORT_HI = 6;
    localparam int HDR_PORT_LO = 5;
    localparam int HDR_REG_HI = 4;
    localparam logic [4:0] REG_CTL = 5'h00;
    localparam logic [4:0] REG_STS = 5'h01;

    // ----------------------------------------
    // negotiation_control fields
    // ----------------------------------------
    localparam int CTL_SRST_BIT = 15;
    localparam int CTL_LOOP_BIT = 14;
    localparam int CTL_ANEN_BIT = 12;
    localparam int CTL_PDN_BIT = 11;
    localparam int CTL_RST_BIT = 9;
    localparam int CTL_DUP_BIT = 8;
    localparam int CTL_COLT_BIT = 7;
    localparam logic [15:0] CTL_STORE_MASK = 16'h5b80;
    localparam logic [15:0] CTL_RESET = 16'h1000;

    // ----------------------------------------
    // negotiation_status fields
    // ----------------------------------------
    localparam int STS_ANC_BIT = 5;
    localparam int STS_RF_BIT = 4;
    localparam int STS_LNK_BIT = 2;
    localparam int STS_JAB_BIT = 1;
    localparam logic [15:0] STS_FIXED = 16'h1849;

    // ----------------------------------------
    // types
    // ----------------------------------------
    typedef enum logic [3:0] {
        MS_IDLE = 4'b0001,
        MS_HDR  = 4'b0010,
        MS_TA   = 4'b0100,
        MS_DATA = 4'b1000
    } pacr_mstate_t;

    // per-port state coming from the negotiation and link logic
    typedef struct packed {
        logic neg_done;
        logic remote_fault;
        logic link_up;
        logic jabber;
        logic neg_full_duplex;
    } pacr_stat_t;

    // per-port controls going to the negotiation and link logic
    typedef struct packed {
        logic neg_enable;
        logic neg_restart;
        logic neg_power_down;
        logic full_duplex;
        logic loopback;
        logic collision_test;
    } pacr_ctl_t;

endpackage

/* core/pacr_port_regs.sv */
`timescale 1ns/1ps
module pacr_port_regs
    import pacr_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    input wire logic clk_en,
    // management access
    input wire logic wr_ctl,
    input wire logic [15:0] wr_data,
    input wire logic rd_sts,
    // port state and controls
    input wire pacr_stat_t stat,
    output pacr_ctl_t ctl_o,
    // register images
    output logic [15:0] ctl_q,
    output logic [15:0] sts_q
);

    logic [15:0] ctl_ff;
    logic [11:0] srst_cnt_ff;
    logic rf_ff;
    logic done_d_ff;
    logic restart_ff;
    logic srst_busy;
    logic srst_go;
    logic done_rise;

    assign srst_busy = (srst_cnt_ff != '0);
    assign srst_go = wr_ctl & wr_data[CTL_SRST_BIT];
    assign done_rise = stat.neg_done & ~done_d_ff;

    // ----------------------------------------
    // soft reset timer
    // ----------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            srst_cnt_ff <= '0;
        end else if (clk_en) begin
            if (srst_go) begin
                srst_cnt_ff <= SRST_LOAD;
            end else if (srst_busy) begin
                srst_cnt_ff <= srst_cnt_ff - 12'h001;
            end
        end
    end

    // ----------------------------------------
    // control storage
    // ----------------------------------------
    // only writable positions are kept, so reserved ones cannot leak
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ctl_ff <= CTL_RESET;
        end else if (clk_en) begin
            if (srst_go || srst_busy) begin
                ctl_ff <= CTL_RESET;
            end else begin
                if (wr_ctl) begin
                    ctl_ff <= wr_data & CTL_STORE_MASK;
                end
                // writing zero leaves restart alone; a new request beats completion
                if (wr_ctl && wr_data[CTL_RST_BIT]) begin
                    ctl_ff[CTL_RST_BIT] <= 1'b1;
                end else if (done_rise) begin
                    ctl_ff[CTL_RST_BIT] <= 1'b0;
                end else begin
                    ctl_ff[CTL_RST_BIT] <= ctl_ff[CTL_RST_BIT];
                end
            end
        end
    end

    // ----------------------------------------
    // restart pulse and completion edge
    // ----------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            restart_ff <= 1'b0;
            done_d_ff <= 1'b0;
        end else if (clk_en) begin
            restart_ff <= wr_ctl & wr_data[CTL_RST_BIT] & ~srst_go & ~srst_busy;
            done_d_ff <= stat.neg_done;
        end
    end

    // ----------------------------------------
    // remote fault, cleared by a status read
    // ----------------------------------------
    // a fault in the same cycle as the read survives it
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rf_ff <= 1'b0;
        end else if (clk_en) begin
            rf_ff <= stat.remote_fault | (rf_ff & ~rd_sts & ~srst_go);
        end
    end

    // ----------------------------------------
    // register images and controls
    // ----------------------------------------
    always_comb begin
        ctl_q = ctl_ff;
        ctl_q[CTL_SRST_BIT] = srst_busy;
        sts_q = STS_FIXED;
        sts_q[STS_ANC_BIT] = stat.neg_done & ctl_ff[CTL_ANEN_BIT]
            & ~ctl_ff[CTL_PDN_BIT] & ~srst_busy;
        sts_q[STS_RF_BIT] = rf_ff;
        sts_q[STS_LNK_BIT] = stat.link_up;
        sts_q[STS_JAB_BIT] = stat.jabber;
    end

    // forced duplex only counts while the negotiation enable bit is clear
    always_comb begin
        ctl_o.neg_enable = ctl_ff[CTL_ANEN_BIT] & ~ctl_ff[CTL_PDN_BIT];
        ctl_o.neg_restart = restart_ff;
        ctl_o.neg_power_down = ctl_ff[CTL_PDN_BIT];
        ctl_o.full_duplex = ctl_ff[CTL_ANEN_BIT] ? stat.neg_full_duplex
            : ctl_ff[CTL_DUP_BIT];
        ctl_o.loopback = ctl_ff[CTL_LOOP_BIT];
        ctl_o.collision_test = ctl_ff[CTL_COLT_BIT];
    end

endmodule

/* tb/pacr_mgmt_checker.sv */
`timescale 1ns/1ps
module pacr_mgmt_checker
    import pacr_pkg::*;
(
    // clock, reset, enable
    input wire logic clk,
    input wire logic reset_n,
    input wire logic clk_en,
    // management pins
    input wire logic mdc,
    input wire logic mdio_o,
    input wire logic mdio_oe_n,
    // port controls and data paths
    input wire pacr_stat_t [PORTS-1:0] port_stat,
    input wire pacr_ctl_t [PORTS-1:0] port_ctl,
    input wire logic [PORTS-1:0] port_transmit_data,
    input wire logic [PORTS-1:0] port_transmit_enable,
    input wire logic [PORTS-1:0] port_receive_data,
    input wire logic [PORTS-1:0] port_collision,
    input wire logic [PORTS-1:0] net_transmit_data,
    input wire logic [PORTS-1:0] net_transmit_enable
);
    default clocking cb @(posedge clk); endclocking
    logic mdc_d_ff;
    logic [4:0] drv_rises_ff;
    // raw mdc rises while the device holds the line; a read drives 17 slots at most
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            mdc_d_ff <= 1'b0;
            drv_rises_ff <= 5'h00;
        end else begin
            mdc_d_ff <= mdc;
            if (mdio_oe_n) drv_rises_ff <= 5'h00;
            else if (mdc && !mdc_d_ff) drv_rises_ff <= drv_rises_ff + 5'h01;
        end
    end
    sequence s_line_free;
        mdio_oe_n ##0 mdio_o;
    endsequence
    a_idle_high: assert property (disable iff (!reset_n) mdio_oe_n |-> s_line_free)
        else $error("released data line not high");
    a_drive_span: assert property (disable iff (!reset_n) drv_rises_ff <= 5'd17)
        else $error("read drive lasts too many bits");
    // one set per port, since each port owns its own registers
    for (genvar i = 0; i < PORTS; i++) begin : g_port
        a_loop_rx: assert property (disable iff (!reset_n) clk_en && port_ctl[i].loopback
            |=> port_receive_data[i] == $past(port_transmit_data[i]))
            else $error("loopback receive data wrong");
        a_loop_quiet: assert property (disable iff (!reset_n) clk_en && port_ctl[i].loopback
            |=> !net_transmit_enable[i] && !net_transmit_data[i])
            else $error("network transmit active in loopback");
        a_coll_test: assert property (disable iff (!reset_n)
            clk_en && port_ctl[i].collision_test && port_transmit_enable[i] |=> port_collision[i])
            else $error("collision test gave no collision");
        a_dup_follow: assert property (disable iff (!reset_n) port_ctl[i].neg_enable
            |-> port_ctl[i].full_duplex == port_stat[i].neg_full_duplex)
            else $error("duplex not from negotiation");
        a_pdn_halts: assert property (disable iff (!reset_n) port_ctl[i].neg_power_down
            |-> !port_ctl[i].neg_enable)
            else $error("negotiation on during power-down");
        a_restart_pulse: assert property (disable iff (!reset_n)
            clk_en && port_ctl[i].neg_restart |=> !port_ctl[i].neg_restart)
            else $error("restart pulse too long");
        a_reset_dflt: assert property (disable iff (!reset_n) $rose(reset_n)
            |-> port_ctl[i].neg_enable && !port_ctl[i].loopback && mdio_oe_n)
            else $error("controls not at defaults after reset");
    end
endmodule
bind pacr_mgmt_top pacr_mgmt_checker u_chk (.clk(clk), .reset_n(reset_n), .clk_en(clk_en),
    .mdc(mdc), .mdio_o(mdio_o), .mdio_oe_n(mdio_oe_n), .port_stat(port_stat),
    .port_ctl(port_ctl), .port_transmit_data(port_transmit_data),
    .port_transmit_enable(port_transmit_enable), .port_receive_data(port_receive_data),
    .port_collision(port_collision), .net_transmit_data(net_transmit_data),
    .net_transmit_enable(net_transmit_enable));

/* tb/pacr_station.sv */
`timescale 1ns/1ps
module pacr_station
    import pacr_pkg::*;
(
    // clock
    input wire logic clk,
    // management pins
    input wire logic mdio_o,
    input wire logic mdio_oe_n,
    output logic mdc,
    output logic mdio_i
);
    logic sta_o;
    logic sta_oe_n;
    // pull-up wins when nobody drives the line
    assign mdio_i = (mdio_oe_n ? 1'b1 : mdio_o) & (sta_oe_n ? 1'b1 : sta_o);
    // mdc stands low between frames
    initial begin
        mdc = 1'b0;
        sta_o = 1'b1;
        sta_oe_n = 1'b1;
    end
    // one 16-cycle mdc period; sample just before the rise
    task automatic slot(input logic drive, input logic val, output logic seen);
        @(posedge clk);
        mdc <= 1'b0;
        sta_oe_n <= ~drive;
        sta_o <= val;
        repeat (8) @(posedge clk);
        seen = mdio_i;
        mdc <= 1'b1;
        repeat (7) @(posedge clk);
    endtask
    // preamble, start, op, address, turnaround, 16 data bits msb first
    task automatic frame(input logic rd, input logic [4:0] phy, input logic [4:0] regad,
                         input logic [15:0] wdat, output logic [15:0] rdat);
        logic [15:0] hdr;
        logic s;
        hdr = {4'b1101, rd ? OP_RD : OP_WR, phy, regad};
        for (int i = 15; i >= 0; i--) slot(1'b1, hdr[i], s);
        slot(!rd, 1'b1, s);
        slot(!rd, 1'b0, s);
        for (int i = 15; i >= 0; i--) begin
            slot(!rd, wdat[i], s);
            rdat[i] = s;
        end
        @(posedge clk);
        mdc <= 1'b0;
        sta_oe_n <= 1'b1;
        repeat (16) @(posedge clk);
    endtask
endmodule

/* tb/port_autoneg_control_status_regs_tb.sv */
`timescale 1ns/1ps
module port_autoneg_control_status_regs_tb
    import pacr_pkg::*;
;
    localparam logic [2:0] CHIP = 3'h5; // arbitrary strap value
    logic clk, reset_n, clk_en, mdc, mdio_i, mdio_o, mdio_oe_n;
    pacr_stat_t [PORTS-1:0] pst;
    pacr_ctl_t [PORTS-1:0] pct;
    logic [PORTS-1:0] ptd, pte, prd, pco, nrd, nco, ntd, nte;
    int num_errors = 0;
    int cmp_count = 0;
    pacr_mgmt_top u_dut (.clk(clk), .reset_n(reset_n), .clk_en(clk_en), .mdc(mdc),
        .mdio_i(mdio_i), .mdio_o(mdio_o), .mdio_oe_n(mdio_oe_n), .chip_addr_strap(CHIP),
        .port_stat(pst), .port_ctl(pct), .port_transmit_data(ptd),
        .port_transmit_enable(pte), .port_receive_data(prd), .port_collision(pco),
        .net_receive_data(nrd), .net_collision(nco), .net_transmit_data(ntd),
        .net_transmit_enable(nte));
    pacr_station u_sta (.clk(clk), .mdio_o(mdio_o), .mdio_oe_n(mdio_oe_n), .mdc(mdc),
        .mdio_i(mdio_i));
    // ----------------------------------------
    // compares, access tasks, closing
    // ----------------------------------------
    task automatic chk_word(input string what, input logic [15:0] exp, input logic [15:0] got);
        cmp_count++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic chk_bits(input string what, input logic [5:0] exp, input logic [5:0] got);
        cmp_count++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wr(input logic [1:0] p, input logic [4:0] r, input logic [15:0] d);
        logic [15:0] q;
        u_sta.frame(1'b0, {CHIP, p}, r, d, q);
        repeat (4) @(posedge clk);
    endtask
    task automatic rd_chk(input logic [2:0] c, input logic [1:0] p, input logic [4:0] r,
                          input logic [15:0] e);
        logic [15:0] q;
        u_sta.frame(1'b1, {c, p}, r, 16'h0000, q);
        chk_word("register read", e, q);
    endtask
    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    // 250 MHz clock
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    // watchdog: the sequence needs about 18400 cycles
    initial begin
        repeat (60000) @(posedge clk);
        num_errors++;
        complete_run();
    end
    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        reset_n = 1'b0;
        clk_en = 1'b1;
        pst = '0;
        {ptd, pte, nrd, nco} = '0;
        repeat (5) @(posedge clk);
        reset_n <= 1'b1;
        repeat (12) @(posedge clk);
        for (int p = 0; p < PORTS; p++) begin
            rd_chk(CHIP, 2'(p), REG_CTL, 16'h1000);
            rd_chk(CHIP, 2'(p), REG_STS, 16'h1849);
        end
        wr(2'd1, REG_CTL, 16'h7dff);
        rd_chk(CHIP, 2'd1, REG_CTL, 16'h5980);
        chk_bits("port1 controls", 6'h0b, pct[1]);
        rd_chk(CHIP, 2'd0, REG_CTL, 16'h1000);
        // port1 in loopback with collision test, port0 normal
        ptd <= 4'h2;
        pte <= 4'h2;
        nrd <= 4'h1;
        nco <= 4'h1;
        repeat (3) @(posedge clk);
        chk_bits("receive data", 6'h03, {2'b00, prd});
        chk_bits("network transmit", 6'h00, {2'b00, ntd | nte});
        chk_bits("collision", 6'h03, {2'b00, pco});
        pte <= 4'h0;
        wr(2'd1, REG_CTL, 16'h0100);
        chk_bits("forced full", 6'h04, pct[1]);
        wr(2'd1, REG_CTL, 16'h0000);
        chk_bits("forced half", 6'h00, pct[1]);
        wr(2'd1, REG_CTL, 16'h1100);
        chk_bits("duplex ignored", 6'h20, pct[1]);
        wr(2'd2, REG_CTL, 16'h1200);
        rd_chk(CHIP, 2'd2, REG_CTL, 16'h1200);
        pst[2].neg_done <= 1'b1;
        repeat (4) @(posedge clk);
        rd_chk(CHIP, 2'd2, REG_CTL, 16'h1000);
        rd_chk(CHIP, 2'd2, REG_STS, 16'h1869);
        pst[3].remote_fault <= 1'b1;
        pst[3].link_up <= 1'b1;
        pst[3].jabber <= 1'b1;
        @(posedge clk);
        pst[3].remote_fault <= 1'b0;
        rd_chk(CHIP, 2'd3, REG_STS, 16'h185f);
        rd_chk(CHIP, 2'd3, REG_STS, 16'h184f);
        wr(2'd3, REG_STS, 16'hffff);
        rd_chk(CHIP, 2'd3, REG_STS, 16'h184f);
        rd_chk(~CHIP, 2'd0, REG_CTL, 16'hffff);
        rd_chk(CHIP, 2'd0, 5'h02, 16'hffff);
        wr(2'd0, REG_CTL, 16'hc080);
        rd_chk(CHIP, 2'd0, REG_CTL, 16'h9000);
        repeat (2600) @(posedge clk);
        rd_chk(CHIP, 2'd0, REG_CTL, 16'h1000);
        // enable low must freeze the receive path of a normal port
        clk_en <= 1'b0;
        nrd <= 4'h0;
        repeat (3) @(posedge clk);
        chk_bits("frozen receive", 6'h01, {2'b00, prd});
        clk_en <= 1'b1;
        repeat (2) @(posedge clk);
        chk_bits("thawed receive", 6'h00, {2'b00, prd});
        rd_chk(CHIP, 2'd1, REG_CTL, 16'h1100);
        complete_run();
    end
endmodule
